// *** rtl/bridge_command_pkg.sv ***
/*
 * constants, field positions and carrier structs for the bridge command
 * register block. assumes a single core clock domain.
 */
package bridge_command_pkg;

    localparam logic [11:0] bridge_command_offset = 12'h004;
    localparam logic [11:0] bridge_status_offset  = 12'h006;
    localparam logic [15:0] bridge_command_reset  = 16'h0000;
    localparam logic [15:0] bridge_status_reset   = 16'h0000;
    localparam logic [15:0] bridge_command_wmask  = 16'h0547;
    localparam logic [15:0] bridge_status_w1c     = 16'h4100;

    localparam int io_space_decode_en_bit     = 0;
    localparam int mem_space_decode_en_bit    = 1;
    localparam int bus_master_en_bit          = 2;
    localparam int poison_report_en_bit       = 6;
    localparam int system_error_report_en_bit = 8;
    localparam int own_interrupt_suppress_bit = 10;
    localparam int master_poison_flag_bit     = 8;
    localparam int signalled_sys_error_bit    = 14;

    localparam logic [2:0] cpl_status_ur = 3'h1;

    // configuration access: byte address of the dword, byte enables, data
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] data;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } cfg_rsp_t;

    // request arriving from a subordinate device on the secondary side
    typedef enum logic [2:0] {
        up_mem      = 3'b000,
        up_io       = 3'b001,
        up_msg      = 3'b010,
        up_cpl      = 3'b011,
        up_err_cor  = 3'b100,
        up_err_nonf = 3'b101,
        up_err_fat  = 3'b110,
        up_other    = 3'b111
    } up_kind_t;

    typedef struct packed {
        logic     valid;
        up_kind_t kind;
        logic     non_posted;
    } up_req_t;

    // primary-side downstream request window hits
    typedef struct packed {
        logic valid;
        logic is_io;
        logic io_hit;
        logic mem_hit;
        logic prefetch_hit;
    } down_req_t;

    typedef struct packed {
        logic       forward;
        logic       drop;
        logic       send_ur;
        logic [2:0] cpl_status;
    } up_dec_t;

    typedef struct packed {
        logic poisoned_cpl;
        logic poisoned_write;
        logic err_nonfatal;
        logic err_fatal;
        logic nonfatal_report_en;
        logic fatal_report_en;
    } err_evt_t;

endpackage : bridge_command_pkg

// *** rtl/bridge_command_register.sv ***
/*
 * bridge command register of a switch port bridge function, with the
 * command-gated decode of requests, error reporting and interrupt gating.
 * assumes all inputs come from logic on clk_i; status flags live here
 * only so far as the command register steers them.
 */
// Overview of operation
// R1: io decode enable low ignores primary io requests in window; high claims them
// R2: memory decode enable low claims no memory or prefetchable window request
// R3: bus master enable low blocks upstream memory and io requests, msi included
// R4: blocked non-posted upstream requests get an unsupported request completion
// R5: bus master enable never blocks completions or message forwarding
// R6: poison enable high sets master poison flag on poisoned completion or write
// R7: poison enable low never sets the master poison flag
// R8: fatal and nonfatal errors reported when system error or device enables set
// R9: secondary fatal and nonfatal messages forwarded only with system error enable
// R10: secondary correctable error messages always forwarded
// R11: suppress bit negates own interrupt; resolved state follows, may deassert
// R12: suppress bit leaves forwarded secondary interrupts untouched
// R13: unused and reserved command bits read zero; writable bits reset zero
// R14: master poison flag is status bit 8, write one clears, resets zero
// R15: signalled system error flag sets on sent error message with enable
// R16: writes touch only writable bits selected by byte enables
`timescale 1ns/1ps

module bridge_command_register (
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire bridge_command_pkg::cfg_req_t  cfg_req_i,
    output bridge_command_pkg::cfg_rsp_t       cfg_rsp_o,
    input  wire bridge_command_pkg::down_req_t down_req_i,
    output logic                               down_claim_o,
    input  wire bridge_command_pkg::up_req_t   up_req_i,
    output bridge_command_pkg::up_dec_t        up_dec_o,
    input  wire bridge_command_pkg::err_evt_t  err_evt_i,
    output logic                               err_report_o,
    output logic                               err_fwd_o,
    input  wire logic                          own_int_req_i,
    input  wire logic                          fwd_int_i,
    output logic                               own_int_o,
    output logic                               int_assert_msg_o,
    output logic                               int_deassert_msg_o,
    output logic                               fwd_int_o,
    output logic [15:0]                        bridge_command_o,
    output logic [15:0]                        bridge_status_o
);
    import bridge_command_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [15:0] bridge_command;
    logic [15:0] next_bridge_command;
    logic [15:0] bridge_status;
    logic [15:0] next_bridge_status;
    cfg_rsp_t    next_cfg_rsp;
    logic [15:0] cmd_lane_mask;
    logic [15:0] sts_lane_mask;
    logic [15:0] sts_clear;
    logic        sts_set_poison;
    logic        sts_set_sse;
    logic        cmd_hit;
    logic        wr_cmd;
    logic        wr_sts;
    logic        err_fwd_send;

    always_comb begin
        cmd_hit  = cfg_req_i.addr == bridge_command_offset;
        wr_cmd   = cfg_req_i.valid && cfg_req_i.write && cmd_hit;
        // status shares the dword, upper half lanes
        wr_sts   = wr_cmd;
        cmd_lane_mask = {{8{cfg_req_i.byte_en[1]}}, {8{cfg_req_i.byte_en[0]}}};
        sts_lane_mask = {{8{cfg_req_i.byte_en[3]}}, {8{cfg_req_i.byte_en[2]}}};
        next_bridge_command = bridge_command;
        if (wr_cmd) begin
            next_bridge_command = (bridge_command & ~(cmd_lane_mask & bridge_command_wmask))
                                | (cfg_req_i.data[15:0] & cmd_lane_mask
                                   & bridge_command_wmask); // R16 R13
        end
        sts_clear = wr_sts ? (cfg_req_i.data[31:16] & sts_lane_mask & bridge_status_w1c)
                           : 16'h0000; // R14
        // set beats clear in the same cycle, so no event is lost
        sts_set_poison = bridge_command[poison_report_en_bit]
                       && (err_evt_i.poisoned_cpl || err_evt_i.poisoned_write); // R6 R7
        sts_set_sse    = bridge_command[system_error_report_en_bit]
                       && err_fwd_send; // R15
        next_bridge_status = bridge_status & ~sts_clear;
        if (sts_set_poison) begin
            next_bridge_status[master_poison_flag_bit] = 1'b1; // R6
        end
        if (sts_set_sse) begin
            next_bridge_status[signalled_sys_error_bit] = 1'b1; // R15
        end
        next_cfg_rsp.valid = cfg_req_i.valid && !cfg_req_i.write;
        next_cfg_rsp.data  = cmd_hit ? {bridge_status, bridge_command} : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // request decode

    logic    next_down_claim;
    up_dec_t next_up_dec;
    logic    bme;

    always_comb begin
        bme = bridge_command[bus_master_en_bit];
        next_down_claim = 1'b0;
        if (down_req_i.valid) begin
            if (down_req_i.is_io) begin
                next_down_claim = down_req_i.io_hit
                                && bridge_command[io_space_decode_en_bit]; // R1
            end else begin
                next_down_claim = (down_req_i.mem_hit || down_req_i.prefetch_hit)
                                && bridge_command[mem_space_decode_en_bit]; // R2
            end
        end
        next_up_dec = '0;
        if (up_req_i.valid) begin
            case (up_req_i.kind)
                up_mem, up_io: begin
                    next_up_dec.forward = bme; // R3
                    next_up_dec.drop    = !bme && !up_req_i.non_posted;
                    next_up_dec.send_ur = !bme && up_req_i.non_posted; // R4
                    next_up_dec.cpl_status = (!bme && up_req_i.non_posted)
                                           ? cpl_status_ur : 3'h0; // R4
                end
                up_err_nonf, up_err_fat: begin
                    next_up_dec.forward = bridge_command[system_error_report_en_bit]; // R9
                    next_up_dec.drop    = !bridge_command[system_error_report_en_bit];
                end
                up_err_cor: begin
                    next_up_dec.forward = 1'b1; // R10
                end
                default: begin
                    next_up_dec.forward = 1'b1; // R5
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error reporting

    logic next_err_report;
    logic own_err;

    always_comb begin
        own_err = (err_evt_i.err_nonfatal && (bridge_command[system_error_report_en_bit]
                                              || err_evt_i.nonfatal_report_en))
               || (err_evt_i.err_fatal && (bridge_command[system_error_report_en_bit]
                                           || err_evt_i.fatal_report_en)); // R8
        next_err_report = own_err; // R8
        // forwarded secondary fatal/nonfatal messages also count as sent
        err_fwd_send = own_err || (up_req_i.valid && next_up_dec.forward
                       && (up_req_i.kind == up_err_nonf || up_req_i.kind == up_err_fat));
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt gating

    logic next_own_int;
    logic next_assert_msg;
    logic next_deassert_msg;

    always_comb begin
        // resolved state moves one edge after the suppress write is taken, hence a deassert
        next_own_int      = own_int_req_i && !bridge_command[own_interrupt_suppress_bit]; // R11
        next_assert_msg   = next_own_int && !own_int_o;
        next_deassert_msg = !next_own_int && own_int_o; // R11
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers, one process per group

    // register group: command, status and read answer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bridge_command   <= bridge_command_reset; // R13
            bridge_status    <= bridge_status_reset; // R14
            cfg_rsp_o        <= '0;
            bridge_command_o <= bridge_command_reset;
            bridge_status_o  <= bridge_status_reset;
        end else begin
            bridge_command   <= next_bridge_command;
            bridge_status    <= next_bridge_status;
            cfg_rsp_o        <= next_cfg_rsp;
            bridge_command_o <= next_bridge_command;
            bridge_status_o  <= next_bridge_status;
        end
    end

    // decode group
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            down_claim_o <= 1'b0;
            up_dec_o     <= '0;
        end else begin
            down_claim_o <= next_down_claim;
            up_dec_o     <= next_up_dec;
        end
    end

    // error group
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            err_report_o <= 1'b0;
            err_fwd_o    <= 1'b0;
        end else begin
            err_report_o <= next_err_report;
            err_fwd_o    <= err_fwd_send;
        end
    end

    // interrupt group; forwarded level only delayed, never gated
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            own_int_o          <= 1'b0;
            int_assert_msg_o   <= 1'b0;
            int_deassert_msg_o <= 1'b0;
            fwd_int_o          <= 1'b0;
        end else begin
            own_int_o          <= next_own_int;
            int_assert_msg_o   <= next_assert_msg;
            int_deassert_msg_o <= next_deassert_msg;
            fwd_int_o          <= fwd_int_i; // R12
        end
    end

endmodule : bridge_command_register

// *** testbench/bridge_command_properties.sv ***
/*
 * port checker for the bridge command register.
 * assumes one clock domain and the registered one-cycle answers of the design.
 */
`timescale 1ns/1ps
module bridge_command_properties
    import bridge_command_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire down_req_t   down_req_i,
    input wire logic        down_claim_o,
    input wire up_req_t     up_req_i,
    input wire up_dec_t     up_dec_o,
    input wire err_evt_t    err_evt_i,
    input wire logic        err_report_o,
    input wire logic        own_int_o,
    input wire logic        int_deassert_msg_o,
    input wire logic        fwd_int_i,
    input wire logic        fwd_int_o,
    input wire logic [15:0] bridge_command_o,
    input wire logic [15:0] bridge_status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // blocked non-posted memory or io request from below
    sequence blocked_np;
        up_req_i.valid && up_req_i.non_posted && !bridge_command_o[2]
            && up_req_i.kind inside {up_mem, up_io};
    endsequence
    // own resolved interrupt drops from one edge to the next
    sequence own_int_falls;
        own_int_o ##1 !own_int_o;
    endsequence
    chk_reserved_read_zero: assert property ((bridge_command_o & 16'hfab8) == 16'h0000)
        else $error("reserved command bit set");
    chk_io_decode: assert property (down_req_i.valid && down_req_i.is_io && down_req_i.io_hit
        |=> down_claim_o == $past(bridge_command_o[0])) else $error("io claim mismatch");
    chk_mem_gate: assert property (down_req_i.valid && !down_req_i.is_io && !bridge_command_o[1]
        |=> !down_claim_o) else $error("memory claimed while disabled");
    chk_blocked_ur: assert property (blocked_np |=> up_dec_o.send_ur && !up_dec_o.forward
        && up_dec_o.cpl_status == cpl_status_ur) else $error("blocked request not refused");
    chk_cpl_passes: assert property (up_req_i.valid
        && up_req_i.kind inside {up_cpl, up_msg, up_err_cor}
        |=> up_dec_o.forward) else $error("completion or message held back");
    chk_err_msg_gate: assert property (up_req_i.valid && !bridge_command_o[8]
        && up_req_i.kind inside {up_err_nonf, up_err_fat}
        |=> !up_dec_o.forward) else $error("error message forwarded");
    chk_poison_set: assert property (bridge_command_o[6]
        && (err_evt_i.poisoned_cpl || err_evt_i.poisoned_write)
        |=> bridge_status_o[8]) else $error("poison flag not set");
    chk_poison_quiet: assert property (!bridge_command_o[6] && !bridge_status_o[8]
        |=> !bridge_status_o[8]) else $error("poison flag set while disabled");
    chk_fatal_report: assert property (err_evt_i.err_fatal && bridge_command_o[8]
        |=> err_report_o) else $error("fatal error not reported");
    chk_own_int_off: assert property (bridge_command_o[10] |=> !own_int_o)
        else $error("own interrupt not negated");
    chk_fwd_int_pass: assert property (fwd_int_o == $past(fwd_int_i))
        else $error("forwarded interrupt altered");
    chk_int_deassert: assert property (own_int_falls |-> int_deassert_msg_o)
        else $error("deassert message missing");
    chk_sse_set: assert property (up_req_i.valid && bridge_command_o[8]
        && up_req_i.kind inside {up_err_nonf, up_err_fat}
        |=> bridge_status_o[14]) else $error("signalled system error flag not set");
endmodule : bridge_command_properties

bind bridge_command_register bridge_command_properties chk (.clk_i, .reset_i, .down_req_i,
    .down_claim_o, .up_req_i, .up_dec_o, .err_evt_i, .err_report_o, .own_int_o,
    .int_deassert_msg_o, .fwd_int_i,
    .fwd_int_o, .bridge_command_o, .bridge_status_o);

// *** testbench/cfg_host.sv ***
/*
 * configuration software model issuing one-cycle config requests.
 * assumes reads answer on the taking edge itself, sampled 1 ns after it.
 */
`timescale 1ns/1ps
module cfg_host
    import bridge_command_pkg::*;
(
    input  wire logic     clk_i,
    output cfg_req_t      cfg_req_o,
    input  wire cfg_rsp_t cfg_rsp_i
);
    initial cfg_req_o = '0;
    // idle bus is all zero so no stale address can look valid
    task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        #1 cfg_req_o = '{1'b1, w, a, be, d};
        @(posedge clk_i);
        #1 cfg_req_o = '0;
        q = cfg_rsp_i.valid ? cfg_rsp_i.data : 32'hxxxx_xxxx;
    endtask : access
endmodule : cfg_host

// *** testbench/bridge_command_register_tb.sv ***
/*
 * self-checking bench for the bridge command register.
 * assumes the partner model cfg_host and the bound port checker.
 */
`timescale 1ns/1ps
module bridge_command_register_tb;
    import bridge_command_pkg::*;
    logic      clk_i = 0, reset_i = 1, own_int_req_i = 0, fwd_int_i = 0;
    cfg_req_t  cfg_req_i;
    cfg_rsp_t  cfg_rsp_o;
    down_req_t down_req_i = '0;
    up_req_t   up_req_i = '0;
    up_dec_t   up_dec_o;
    err_evt_t  err_evt_i = '0;
    logic      down_claim_o, err_report_o, own_int_o, fwd_int_o;
    logic      err_fwd_o, int_assert_msg_o, int_deassert_msg_o;
    logic [15:0] cmd, sts;
    int n_fail = 0, comparisons = 0, cycles = 0;
    always #10 clk_i = ~clk_i;
    cfg_host host (.clk_i, .cfg_req_o(cfg_req_i), .cfg_rsp_i(cfg_rsp_o));
    bridge_command_register dut (.clk_i, .reset_i, .cfg_req_i, .cfg_rsp_o, .down_req_i,
        .down_claim_o, .up_req_i, .up_dec_o, .err_evt_i, .err_report_o, .err_fwd_o,
        .own_int_req_i, .fwd_int_i, .own_int_o, .int_assert_msg_o, .int_deassert_msg_o,
        .fwd_int_o, .bridge_command_o(cmd), .bridge_status_o(sts));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step; @(posedge clk_i); #1; endtask : step
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        host.access(1'b1, 12'h004, be, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.access(1'b0, a, 4'hf, 32'h0, q);
        check(q, exp);
        if (a == 12'h004) check({sts, cmd}, exp);
    endtask : rd
    // every upstream kind but the catch-all, non-posted
    task automatic up_loop(input logic en);
        for (int k = 0; k < 7; k++) begin
            up_req_i = '{1'b1, up_kind_t'(k), 1'b1};
            step;
            check(up_dec_o.forward, en || (k >= 2 && k <= 4));
            check(up_dec_o.send_ur, !en && k < 2);
            check(up_dec_o.drop, !en && k >= 5);
            check(err_fwd_o, en && k >= 5);
        end
        up_req_i = '0;
        $display("upstream test done");
    endtask : up_loop
    task automatic down_loop(input logic en);
        for (int j = 0; j < 3; j++) begin
            down_req_i = '{1'b1, j == 0, j == 0, j == 1, j == 2};
            step;
            check(down_claim_o, en);
        end
        down_req_i = '0;
        $display("decode test done");
    endtask : down_loop
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // about 70 cycles expected; generous ceiling
    always @(posedge clk_i) if (++cycles == 3000) begin
        n_fail++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        #1 reset_i = 0;
        rd(12'h004, 32'h0000_0000);
        wr(4'h3, 32'hffff_ffff);
        rd(12'h004, 32'h0000_0547);
        rd(12'h008, 32'h0000_0000);
        wr(4'h1, 32'h0000_0000);
        rd(12'h004, 32'h0000_0500);
        err_evt_i.poisoned_cpl = 1; step; err_evt_i = '0;
        rd(12'h004, 32'h0000_0500);
        wr(4'h3, 32'h0000_0547);
        err_evt_i.poisoned_write = 1; step; err_evt_i = '0;
        rd(12'h004, 32'h0100_0547);
        wr(4'hc, 32'h0100_0000);
        rd(12'h004, 32'h0000_0547);
        $display("register test done");
        up_loop(1'b1);
        rd(12'h004, 32'h4000_0547);
        down_loop(1'b1);
        err_evt_i.err_fatal = 1; step; err_evt_i = '0;
        check(err_report_o, 1'b1);
        check(err_fwd_o, 1'b1);
        own_int_req_i = 1; fwd_int_i = 1; step; step;
        check(own_int_o, 1'b0);
        check(fwd_int_o, 1'b1);
        wr(4'h3, 32'h0000_0147);
        step;
        check(own_int_o, 1'b1);
        check(int_assert_msg_o, 1'b1);
        wr(4'h3, 32'h0000_0547);
        step;
        check(own_int_o, 1'b0);
        check(int_deassert_msg_o, 1'b1);
        $display("interrupt test done");
        wr(4'h3, 32'h0000_0000);
        up_loop(1'b0);
        down_loop(1'b0);
        tally_and_finish();
    end
endmodule : bridge_command_register_tb
